// file: logic/bpg_pkg.sv
// constants, enumerations and carriers for the burst pulse generator
`default_nettype none
package bpg_pkg;
    // trigger modes
    typedef enum logic [2:0] {
        TRIG_FREE    = 3'b000,
        TRIG_DELAYED = 3'b001,
        TRIG_EXT     = 3'b010,
        TRIG_EXT_DLY = 3'b011,
        TRIG_GATED   = 3'b100
    } bpg_trig_type;
    // burst length minus one
    typedef enum logic [1:0] {
        BURST_SINGLE  = 2'b00,
        BURST_DOUBLET = 2'b01,
        BURST_TRIPLET = 2'b10,
        BURST_QUAD    = 2'b11
    } bpg_burst_type;
    // burst sequencer phase
    typedef enum logic [1:0] {
        PH_IDLE  = 2'b00,
        PH_DELAY = 2'b01,
        PH_WIDTH = 2'b10
    } bpg_phase_type;

    localparam int SYS_MHZ      = 100;
    localparam int SLOW_MHZ     = 10;
    localparam int MARGIN_100NS = 50;
    localparam int MARGIN_40NS  = 125;
    localparam int MARGIN_10NS  = 500;
    // least times round up to whole pulse-clock cycles
    localparam int MARGIN_100_CYC = (MARGIN_100NS * 100 + 999) / 1000;
    localparam int MARGIN_40_CYC  = (MARGIN_40NS * 40 + 999) / 1000;
    localparam int MARGIN_10_CYC  = (MARGIN_10NS * 10 + 999) / 1000;
    localparam int DIV_STEPS      = 32;

    // widths and delays, in pulse-clock cycles
    typedef struct packed {
        logic [23:0] first_pulse_width;
        logic [23:0] second_pulse_width;
        logic [23:0] third_pulse_width;
        logic [23:0] fourth_pulse_width;
        logic [23:0] first_pulse_delay;
        logic [23:0] second_pulse_delay;
        logic [23:0] third_pulse_delay;
        logic [23:0] fourth_pulse_delay;
    } bpg_timing_type;

    // stepped first-delay sweep
    typedef struct packed {
        logic        enable;
        logic [23:0] start;
        logic [23:0] stop;
        logic [23:0] size;
        logic [31:0] dwell;
    } bpg_step_type;

    typedef struct packed {
        logic          mod_en;
        logic          ext_source;
        bpg_trig_type  trig_mode;
        bpg_burst_type burst_mode;
        logic          fast_clk;
        logic          rf_on_polarity;
        logic          trig_rising;
        logic          prf_sel;
    } bpg_ctrl_type;

    typedef struct packed {
        logic          sync1;
        logic          sync2;
        logic          sync3;
        logic [7:0]    acc;
        logic          tick;
        logic          pend;
        bpg_phase_type ph;
        logic [1:0]    idx;
        logic [31:0]   cnt;
        logic [31:0]   pcnt;
        logic [23:0]   d1;
        logic [31:0]   dwell;
        logic          step_on;
        logic [31:0]   dq;
        logic [32:0]   dr;
        logic [5:0]    dn;
        logic [31:0]   conv;
        logic          rf_on;
        logic          mod_pulse;
        logic          sync;
        logic          err;
    } bpg_state_type;
endpackage
`default_nettype wire

// file: logic/bpg_top.sv
// burst pulse generator gating the rf output
//
// Contract
// - time everything from a 10 MHz or a 40/100 MHz pulse clock
// - period exceeds widths plus delays by 50, 125 or 500 ns per clock
// - flag an error when the pulse parameters are invalid
// - first delay used only in delayed and triggered-with-delay modes
// - four widths and delays; burst mode picks how many are used
// - free run repeats the burst each period, no first delay
// - delayed mode repeats the burst each period after first delay
// - triggered mode emits one burst per active edge, no first delay
// - triggered-with-delay starts the burst first delay after the edge
// - gated mode makes single pulses per period while gate is active
// - rising or falling edge of the external input is selectable
// - repetition given as period or frequency, converted as needed
// - polarity selects low or high level as rf on
// - stepped delay starts at start, steps each dwell, ends at stop
// - a final partial step is omitted
// - start may lie above or below stop; step direction follows
// - check start and stop as first delay; step beyond span is error
// - external source gates rf directly with the selected polarity
// - sync output follows the internal pulses under internal timing; here only in free run, delayed and gated modes, low in triggered modes
`timescale 1ns/10ps
`default_nettype none
module bpg_top #(
    parameter int FAST_MHZ = 100
) (
    input  wire logic               clk_i,
    input  wire logic               srst_i,
    input  wire bpg_pkg::bpg_ctrl_type   ctrl_i,
    input  wire bpg_pkg::bpg_timing_type timing_i,
    input  wire bpg_pkg::bpg_step_type   step_i,
    input  wire logic [31:0]        period_i,
    input  wire logic [31:0]        prf_i,
    input  wire logic               ext_pulse_i,
    output logic                    rf_on_o,
    output logic                    mod_pulse_o,
    output logic                    sync_o,
    output logic                    error_o,
    output logic [23:0]             first_delay_o
);
    // pulse clock rates in hertz, the dividends of the period divide
    localparam logic [31:0] FAST_HZ = 32'(FAST_MHZ * 1000000);
    localparam logic [31:0] SLOW_HZ = 32'(bpg_pkg::SLOW_MHZ * 1000000);
    localparam logic [31:0] MARGIN_FAST = (FAST_MHZ == 40) ?
        32'(bpg_pkg::MARGIN_40_CYC) : 32'(bpg_pkg::MARGIN_100_CYC);

    // all state sits in one packed struct, registered in one place
    bpg_pkg::bpg_state_type s_q;
    bpg_pkg::bpg_state_type s_d;

    // width and delay of pulse k, selected from the four settings
    function automatic logic [31:0] seg_w(input bpg_pkg::bpg_timing_type t,
                                          input logic [1:0] k);
        logic [23:0] v;
        v = '0;
        unique case (k)
            2'b00: v = t.first_pulse_width;
            2'b01: v = t.second_pulse_width;
            2'b10: v = t.third_pulse_width;
            2'b11: v = t.fourth_pulse_width;
        endcase
        seg_w = (v == 24'h000000) ? 32'h00000001 : {8'h00, v};
    endfunction

    function automatic logic [31:0] seg_d(input bpg_pkg::bpg_timing_type t,
                                          input logic [1:0] k);
        logic [23:0] v;
        v = '0;
        unique case (k)
            2'b00: v = t.first_pulse_delay;
            2'b01: v = t.second_pulse_delay;
            2'b10: v = t.third_pulse_delay;
            2'b11: v = t.fourth_pulse_delay;
        endcase
        seg_d = {8'h00, v};
    endfunction

    logic        dly_mode;
    logic        per_mode;
    logic        gated;
    logic [1:0]  last_idx;
    logic [31:0] period_eff;
    logic [31:0] margin;
    logic [31:0] d1_chk;
    logic [31:0] burst_sum;
    logic [23:0] span;
    logic        edge_act;
    logic        gate_act;
    logic        fire;
    logic [31:0] nxt_d;
    logic [32:0] dr_sh;
    logic [8:0]  acc_n;
    logic [23:0] remain;

    // mode decode shared by the sequencer and the checker
    always_comb begin
        dly_mode = (ctrl_i.trig_mode == bpg_pkg::TRIG_DELAYED) ||
                   (ctrl_i.trig_mode == bpg_pkg::TRIG_EXT_DLY);
        gated    = ctrl_i.trig_mode == bpg_pkg::TRIG_GATED;
        per_mode = (ctrl_i.trig_mode == bpg_pkg::TRIG_FREE) ||
                   (ctrl_i.trig_mode == bpg_pkg::TRIG_DELAYED) || gated;
        last_idx = gated ? 2'b00 : ctrl_i.burst_mode;
        period_eff = ctrl_i.prf_sel ? s_q.conv : period_i;
        margin = ctrl_i.fast_clk ? MARGIN_FAST
                                 : 32'(bpg_pkg::MARGIN_10_CYC);
        span = (step_i.start > step_i.stop) ? step_i.start - step_i.stop
                                            : step_i.stop - step_i.start;
        // the worst first delay of the sweep is the one checked
        d1_chk = '0;
        if (dly_mode) begin
            d1_chk = seg_d(timing_i, 2'b00);
            if (step_i.enable) begin
                d1_chk = {8'h00, (step_i.start > step_i.stop) ?
                                 step_i.start : step_i.stop};
            end
        end
        burst_sum = d1_chk;
        for (int k = 0; k < 4; k++) begin
            if (2'(k) <= last_idx) begin
                burst_sum = burst_sum + seg_w(timing_i, 2'(k));
                if (k != 0) begin
                    burst_sum = burst_sum + seg_d(timing_i, 2'(k));
                end
            end
        end
        gate_act = ctrl_i.trig_rising ? s_q.sync2 : !s_q.sync2;
        edge_act = ctrl_i.trig_rising ? (s_q.sync2 && !s_q.sync3)
                                      : (!s_q.sync2 && s_q.sync3);
    end

    // next-state logic for the whole block
    always_comb begin
        s_d = s_q;
        // input synchroniser; only the second and third stages are looked at
        s_d.sync1 = ext_pulse_i;
        s_d.sync2 = s_q.sync1;
        s_d.sync3 = s_q.sync2;

        // fractional pulse-clock tick: 40 MHz comes out as 2 of every 5
        acc_n = {1'b0, s_q.acc} +
                (ctrl_i.fast_clk ? 9'(FAST_MHZ) : 9'(bpg_pkg::SLOW_MHZ));
        s_d.tick = acc_n >= 9'(bpg_pkg::SYS_MHZ);
        s_d.acc = s_d.tick ? 8'(acc_n - 9'(bpg_pkg::SYS_MHZ)) : acc_n[7:0];

        // period from repetition frequency, one restoring divide at a time
        // a new frequency takes up to two 33-cycle passes to show
        dr_sh = {s_q.dr[31:0], s_q.dq[31]};
        if (s_q.dn == 6'(bpg_pkg::DIV_STEPS)) begin
            s_d.conv = s_q.dq;
            s_d.dq = ctrl_i.fast_clk ? FAST_HZ : SLOW_HZ;
            s_d.dr = '0;
            s_d.dn = '0;
        end else begin
            s_d.dq = {s_q.dq[30:0], 1'b0};
            s_d.dr = dr_sh;
            if (dr_sh >= {1'b0, prf_i} && prf_i != 32'h00000000) begin
                s_d.dr = dr_sh - {1'b0, prf_i};
                s_d.dq[0] = 1'b1;
            end
            s_d.dn = s_q.dn + 6'h01;
        end

        // trigger edges wait for the next tick; a new edge beats the clear
        fire = 1'b0;
        if (per_mode) begin
            if (gated && !gate_act) begin
                s_d.pcnt = '0;
            end else if (s_q.tick) begin
                fire = s_q.pcnt == 32'h00000000;
                s_d.pcnt = (s_q.pcnt + 32'h00000001 >= period_eff) ?
                           32'h00000000 : s_q.pcnt + 32'h00000001;
            end
            s_d.pend = 1'b0;
        end else begin
            fire = s_q.tick && s_q.pend;
            s_d.pend = edge_act || (s_q.pend && !s_q.tick);
            s_d.pcnt = '0;
        end

        // stepped first delay: dwell counted in pulse-clock cycles
        // after its last whole step the sweep wraps back to the start
        s_d.step_on = step_i.enable && dly_mode;
        remain = (step_i.start > step_i.stop) ? s_q.d1 - step_i.stop
                                              : step_i.stop - s_q.d1;
        if (!s_d.step_on) begin
            s_d.d1 = timing_i.first_pulse_delay;
            s_d.dwell = '0;
        end else if (!s_q.step_on) begin
            s_d.d1 = step_i.start;
            s_d.dwell = '0;
        end else if (s_q.tick) begin
            s_d.dwell = s_q.dwell + 32'h00000001;
            if (s_d.dwell >= step_i.dwell) begin
                s_d.dwell = '0;
                if (remain >= step_i.size && step_i.size != 24'h000000) begin
                    s_d.d1 = (step_i.start > step_i.stop) ?
                             s_q.d1 - step_i.size :
                             s_q.d1 + step_i.size;
                end else begin
                    s_d.d1 = step_i.start;
                end
            end
        end

        // burst sequencer; a start while a burst runs is ignored
        nxt_d = '0;
        unique case (s_q.ph)
            bpg_pkg::PH_IDLE: begin
                if (fire && !ctrl_i.ext_source && ctrl_i.mod_en) begin
                    s_d.idx = 2'b00;
                    nxt_d = dly_mode ? {8'h00, s_q.d1} : 32'h00000000;
                    s_d.ph = (nxt_d == 32'h00000000) ? bpg_pkg::PH_WIDTH
                                                     : bpg_pkg::PH_DELAY;
                    s_d.cnt = (nxt_d == 32'h00000000) ?
                              seg_w(timing_i, 2'b00) : nxt_d;
                end
            end
            bpg_pkg::PH_DELAY: begin
                if (s_q.tick) begin
                    s_d.cnt = s_q.cnt - 32'h00000001;
                    if (s_q.cnt <= 32'h00000001) begin
                        s_d.ph = bpg_pkg::PH_WIDTH;
                        s_d.cnt = seg_w(timing_i, s_q.idx);
                    end
                end
            end
            bpg_pkg::PH_WIDTH: begin
                if (s_q.tick) begin
                    s_d.cnt = s_q.cnt - 32'h00000001;
                    if (s_q.cnt <= 32'h00000001) begin
                        if (s_q.idx >= last_idx) begin
                            s_d.ph = bpg_pkg::PH_IDLE;
                        end else begin
                            s_d.idx = s_q.idx + 2'b01;
                            nxt_d = seg_d(timing_i, s_d.idx);
                            s_d.ph = (nxt_d == 32'h00000000) ?
                                     bpg_pkg::PH_WIDTH : bpg_pkg::PH_DELAY;
                            s_d.cnt = (nxt_d == 32'h00000000) ?
                                      seg_w(timing_i, s_d.idx) : nxt_d;
                        end
                    end
                end
            end
            default: s_d.ph = bpg_pkg::PH_IDLE;
        endcase
        if (ctrl_i.ext_source || !ctrl_i.mod_en) begin
            s_d.ph = bpg_pkg::PH_IDLE;
        end

        // rf gating: external pulse passes straight through when chosen
        if (ctrl_i.ext_source) begin
            s_d.rf_on = ctrl_i.mod_en &&
                        (s_q.sync2 == ctrl_i.rf_on_polarity);
            s_d.mod_pulse = s_q.sync2;
        end else begin
            s_d.rf_on = ctrl_i.mod_en && s_q.ph == bpg_pkg::PH_WIDTH;
            s_d.mod_pulse = (s_q.ph == bpg_pkg::PH_WIDTH) ?
                            ctrl_i.rf_on_polarity
                            : !ctrl_i.rf_on_polarity;
        end
        s_d.sync = !ctrl_i.ext_source && ctrl_i.mod_en && per_mode &&
                   s_q.ph == bpg_pkg::PH_WIDTH;

        // parameter check against the current settings
        // triggered modes have no period of their own, so no period check
        s_d.err = !ctrl_i.ext_source && ctrl_i.mod_en &&
                  ((per_mode && burst_sum + margin > period_eff) ||
                   (gated && ctrl_i.burst_mode != bpg_pkg::BURST_SINGLE) ||
                   (ctrl_i.prf_sel && prf_i == 32'h00000000) ||
                   (s_d.step_on && step_i.size > span));
    end

    // single state register
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // every output is a field of the state register
    assign rf_on_o       = s_q.rf_on;
    assign mod_pulse_o   = s_q.mod_pulse;
    assign sync_o        = s_q.sync;
    assign error_o       = s_q.err;
    assign first_delay_o = s_q.d1;

    // checks below are masked while reset is held
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);

    tick_full_a: assert property (ctrl_i.fast_clk && FAST_MHZ == 100 |=>
        s_q.tick) else $error("fast pulse clock missed a tick");
    gated_single_a: assert property (gated && s_q.ph != bpg_pkg::PH_IDLE
        |-> s_q.idx == 2'b00) else $error("gated burst past pulse one");
    trig_nodly_a: assert property (ctrl_i.trig_mode == bpg_pkg::TRIG_EXT &&
        s_q.ph == bpg_pkg::PH_IDLE && fire && ctrl_i.mod_en &&
        !ctrl_i.ext_source |=> s_q.ph == bpg_pkg::PH_WIDTH)
        else $error("triggered burst began with a delay");
    dly_start_a: assert property (dly_mode && s_q.d1 != 24'h000000 &&
        s_q.ph == bpg_pkg::PH_IDLE && fire && ctrl_i.mod_en &&
        !ctrl_i.ext_source |=> s_q.ph == bpg_pkg::PH_DELAY &&
        s_q.cnt == {8'h00, $past(s_q.d1)})
        else $error("delayed burst lost the first delay");
    free_run_a: assert property (ctrl_i.trig_mode == bpg_pkg::TRIG_FREE &&
        fire && ctrl_i.mod_en && !ctrl_i.ext_source &&
        s_q.ph == bpg_pkg::PH_IDLE |=> s_q.ph != bpg_pkg::PH_IDLE)
        else $error("free run skipped a burst");
    ext_bypass_a: assert property (ctrl_i.ext_source && ctrl_i.mod_en
        |=> rf_on_o == ($past(s_q.sync2) == $past(ctrl_i.rf_on_polarity)))
        else $error("external pulse not passed to rf");
    mod_off_a: assert property (!ctrl_i.mod_en ##1 !ctrl_i.mod_en
        |-> !rf_on_o && !sync_o) else $error("rf on while disabled");
    step_range_a: assert property (s_q.step_on && $stable(step_i) |->
        s_q.d1 >= ((step_i.start < step_i.stop) ? step_i.start : step_i.stop)
        && s_q.d1 <= ((step_i.start > step_i.stop) ? step_i.start
        : step_i.stop)) else $error("stepped delay left its span");
    sync_ext_a: assert property (ctrl_i.ext_source |=> !sync_o)
        else $error("sync driven under external timing");
    // further checks on the sequencer and the output stage
    pend_set_a: assert property (!per_mode && edge_act |=> s_q.pend)
        else $error("trigger edge lost before its tick");
    gate_hold_a: assert property (gated && !gate_act |=>
        s_q.pcnt == 32'h00000000) else $error("period ran with gate off");
    err_short_a: assert property (!ctrl_i.ext_source && ctrl_i.mod_en &&
        per_mode && burst_sum + margin > period_eff |=> error_o)
        else $error("short period not flagged");
    rf_width_a: assert property (!ctrl_i.ext_source && ctrl_i.mod_en |=>
        rf_on_o == ($past(s_q.ph) == bpg_pkg::PH_WIDTH))
        else $error("rf does not follow the width phase");
    mod_pol_a: assert property (!ctrl_i.ext_source |=>
        mod_pulse_o == (($past(s_q.ph) == bpg_pkg::PH_WIDTH) ==
        $past(ctrl_i.rf_on_polarity)))
        else $error("modulating pulse has the wrong polarity");
    ext_idle_a: assert property (ctrl_i.ext_source |=>
        s_q.ph == bpg_pkg::PH_IDLE)
        else $error("sequencer ran under external source");
    sync_rf_a: assert property (per_mode && !ctrl_i.ext_source |=>
        sync_o == rf_on_o) else $error("sync left the internal pulses");
endmodule
`default_nettype wire

// file: test/bpg_ext_src.sv
// external trigger, gate and pulse source driving the pulse input pin
`timescale 1ns/10ps
`default_nettype none
module bpg_ext_src (
    input  wire logic clk_i,
    output logic      ext_o
);
    logic lvl_q = 1'b0;

    // the pin is always driven by this source, so it never floats
    assign ext_o = lvl_q;

    // move the resting level just after a clock edge
    task automatic idle(input logic v);
        @(posedge clk_i);
        #1 lvl_q = v;
    endtask

    // one excursion away from rest: a toggle, hold, then toggle back
    task automatic strike(input int hold);
        @(posedge clk_i);
        #1 lvl_q = ~lvl_q;
        repeat (hold) @(posedge clk_i);
        #1 lvl_q = ~lvl_q;
    endtask
endmodule
`default_nettype wire

// file: test/tb.sv
// self-checking bench for the burst pulse generator
`timescale 1ns/10ps
`default_nettype none
module tb;
    // row: trig burst fast prf period w1 w2 d1 d2 | err rises highs
    localparam int NROWS = 16;
    int rows [NROWS][12] = '{
        '{0, 0, 1, -1, 10, 2, 0, 4, 0, 0, 20, 40},
        '{0, 0, 1, -1, 7, 2, 0, 0, 0, 0, -1, 0},
        '{0, 0, 1, -1, 6, 2, 0, 0, 0, 1, -1, 0},
        '{0, 1, 1, -1, 20, 2, 1, 0, 3, 0, 20, 30},
        '{0, 1, 1, -1, 10, 2, 1, 0, 3, 1, -1, 0},
        '{0, 2, 1, -1, 20, 2, 1, 0, 3, 0, 30, 40},
        '{0, 3, 1, -1, 20, 1, 1, 0, 1, 0, 40, 40},
        '{1, 0, 1, -1, 20, 2, 0, 4, 0, 0, 10, 20},
        '{1, 0, 1, -1, 10, 2, 0, 4, 0, 1, -1, 0},
        '{0, 0, 0, -1, 10, 2, 0, 0, 0, 0, 2, 40},
        '{0, 0, 0, -1, 6, 2, 0, 0, 0, 1, -1, 0},
        '{0, 0, 1, 10000000, 0, 2, 0, 0, 0, 0, 20, 40},
        '{0, 0, 1, 0, 10, 2, 0, 0, 0, 1, -1, 0},
        '{4, 1, 1, -1, 100, 2, 1, 0, 3, 1, -1, 0},
        '{4, 0, 1, -1, 10, 2, 0, 0, 0, 0, 0, 0},
        '{2, 0, 1, -1, 4, 2, 0, 0, 0, 0, 0, 0}
    };
    logic                    clk          = 1'b0;
    logic                    srst         = 1'b1;
    bpg_pkg::bpg_ctrl_type   ctrl         = '0;
    bpg_pkg::bpg_timing_type tim          = '0;
    bpg_pkg::bpg_step_type   stp          = '0;
    logic [31:0]             period       = 32'h0;
    logic [31:0]             prf          = 32'h0;
    logic                    ext;
    logic                    rf_on;
    logic                    sync;
    logic                    mod_pulse;
    logic                    err;
    logic [23:0]             first_delay;
    int                      fail_count   = 0;
    int                      total_checks = 0;

    bpg_top #(.FAST_MHZ(100)) bpg_top_i (
        .clk_i(clk), .srst_i(srst), .ctrl_i(ctrl), .timing_i(tim),
        .step_i(stp), .period_i(period), .prf_i(prf), .ext_pulse_i(ext),
        .rf_on_o(rf_on), .mod_pulse_o(mod_pulse), .sync_o(sync),
        .error_o(err), .first_delay_o(first_delay));
    bpg_ext_src bpg_ext_src_i (.clk_i(clk), .ext_o(ext));

    // 100 MHz clock
    always #5 clk = ~clk;

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic results();
        $display("checks=%0d mismatches=%0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic do_reset();
        @(posedge clk);
        #1 srst = 1'b1;
        repeat (8) @(posedge clk);
        #1 srst = 1'b0;
    endtask

    // widths and delays two to four share one value to keep rows short
    task automatic apply(input int r [12], input logic rise);
        @(posedge clk);
        #1;
        ctrl = '{1'b1, 1'b0, bpg_pkg::bpg_trig_type'(r[0]),
                 bpg_pkg::bpg_burst_type'(r[1]), r[2][0], 1'b1, rise,
                 r[3] >= 0};
        tim = {24'(r[5]), 24'(r[6]), 24'(r[6]), 24'(r[6]),
               24'(r[7]), 24'(r[8]), 24'(r[8]), 24'(r[8])};
        stp = '0;
        period = 32'(r[4]);
        prf = (r[3] >= 0) ? 32'(r[3]) : 32'h0;
    endtask

    // counts rf rises, rf high cycles and sync high cycles over n cycles
    task automatic count(input int n, output int ri, output int hi,
                         output int sy, output int first);
        logic last;
        ri = 0;
        hi = 0;
        sy = 0;
        first = -1;
        #2 last = rf_on;
        for (int c = 0; c < n; c++) begin
            @(posedge clk);
            #2;
            if (rf_on === 1'b1 && last !== 1'b1) begin
                ri++;
                if (first < 0) first = c;
            end
            if (rf_on === 1'b1) hi++;
            if (sync === 1'b1) sy++;
            last = rf_on;
        end
    endtask

    // one trigger excursion of 5 cycles; lat is cycles to the first rise
    task automatic trig_run(input int t, input logic rise, input int d1,
                            output int lat, output int ri);
        int h;
        int s;
        int row [12];
        row = '{t, 1, 1, -1, 40, 4, 2, d1, 2, 0, 0, 0};
        do_reset();
        apply(row, rise);
        repeat (10) @(posedge clk);
        fork
            bpg_ext_src_i.strike(5);
        join_none
        count(120, ri, h, s, lat);
    endtask

    // sweep of the first delay; records the first four values it takes
    task automatic sweep(input int st, input int sp, input int m1,
                         input int m2);
        logic [23:0] seen [$];
        logic [23:0] last;
        int          row [12];
        row = '{1, 0, 1, -1, 30, 2, 0, 0, 0, 0, 0, 0};
        do_reset();
        apply(row, 1'b1);
        @(posedge clk);
        #1 stp = '{1'b1, 24'(st), 24'(sp), 24'h3, 32'h14};
        last = 24'h0;
        repeat (400) begin
            @(posedge clk);
            #2;
            if (first_delay !== last && seen.size() < 4) begin
                seen.push_back(first_delay);
                last = first_delay;
            end
        end
        check(32'(seen.size()), 32'h4);
        if (seen.size() == 4) begin
            check(32'(seen[0]), 32'(st));
            check(32'(seen[1]), 32'(m1));
            check(32'(seen[2]), 32'(m2));
            check(32'(seen[3]), 32'(st));
        end
        check(32'(err), 32'h0);
    endtask

    // hang guard, well beyond the roughly 4800 cycles the tests need
    initial begin
        repeat (30000) @(posedge clk);
        fail_count++;
        $display("[ERR] t=%0t watchdog expired", $time);
        results();
    end

    // external source pass-through cases: mod_en pol pin expected
    logic [3:0] xs [4] = '{4'b1111, 4'b1100, 4'b1001, 4'b0110};

    initial begin
        int r;
        int h;
        int s;
        int f;
        int l0;
        int l1;
        do_reset();
        // settle covers the repetition rate conversion
        for (int i = 0; i < NROWS; i++) begin
            do_reset();
            apply(rows[i], 1'b1);
            repeat (80) @(posedge clk);
            #2;
            check(32'(err), 32'(rows[i][9]));
            if (rows[i][10] >= 0) begin
                count(200, r, h, s, f);
                check(r, rows[i][10]);
                check(h, rows[i][11]);
                check(s, h);
            end
            $display("row %0d done", i);
        end
        trig_run(2, 1'b1, 0, l0, r);
        check(r, 2);
        trig_run(2, 1'b1, 7, l1, r);
        check(l1, l0);
        trig_run(3, 1'b1, 7, l1, r);
        check(l1, l0 + 7);
        trig_run(2, 1'b0, 0, l1, r);
        check(l1, l0 + 5);
        $display("trigger test done");
        do_reset();
        apply(rows[14], 1'b1);
        repeat (10) @(posedge clk);
        fork
            bpg_ext_src_i.strike(95);
        join_none
        count(130, r, h, s, f);
        check(r, 10);
        check(s, h);
        $display("gate test done");
        for (int k = 0; k < 4; k++) begin
            @(posedge clk);
            #1 ctrl.ext_source = 1'b1;
            ctrl.mod_en = xs[k][3];
            ctrl.rf_on_polarity = xs[k][2];
            bpg_ext_src_i.idle(xs[k][1]);
            repeat (6) @(posedge clk);
            #2;
            check(32'(rf_on), 32'(xs[k][0]));
            check(32'(sync), 32'h0);
            check(32'(mod_pulse), 32'(xs[k][1]));
        end
        $display("external source test done");
        sweep(2, 8, 5, 8);
        sweep(8, 1, 5, 2);
        @(posedge clk);
        #1 stp.size = 24'h9;
        repeat (3) @(posedge clk);
        #2;
        check(32'(err), 32'h1);
        @(posedge clk);
        #1 stp.size = 24'h3;
        period = 32'he;
        repeat (3) @(posedge clk);
        #2;
        check(32'(err), 32'h1);
        $display("stepped delay test done");
        // reset in mid-run clears every output, then the sweep restarts
        @(posedge clk);
        #1 srst = 1'b1;
        repeat (2) @(posedge clk);
        #2;
        check(32'({rf_on, sync, err, mod_pulse}), 32'h0);
        check(32'(first_delay), 32'h0);
        @(posedge clk);
        #1 srst = 1'b0;
        repeat (2) @(posedge clk);
        #2;
        check(32'(first_delay), 32'h8);
        $display("reset test done");
        results();
    end
endmodule
`default_nettype wire
